//--- dv/pscp_ctrl_tb.sv
// Self-checking bench of the coil-array power controller with an integer model of its loop.
// Assumes the sense model of the far side and a 10 MHz clock.
module pscp_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, arst_n, wr, rd, req, slow, cell_valid;
  logic [7:0]  addr, busy, coil_sel;
  logic [31:0] wdata, rdata;
  logic [15:0] ma, cell_ma;
  logic        leg_a, leg_b, damp, trans;
  int          error_cnt, compares, cyc, ph, tgt, m, u, lim, two, t1, hi, per, dly, e;
  logic [31:0] v;

  pscp_ctrl #(.NCOIL(8)) u_dut (.ref_clk_i(ref_clk), .arst_n_i(arst_n), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .cell_ma_i(cell_ma), .cell_valid_i(cell_valid),
    .coil_busy_i(busy), .coil_sel_o(coil_sel), .leg_a_o(leg_a), .leg_b_o(leg_b),
    .ping_damping_switch_o(damp), .transition_switch_o(trans));
  pscp_sense_model u_sense (.ref_clk_i(ref_clk), .arst_n_i(arst_n), .req_i(req), .slow_i(slow),
    .ma_i(ma), .cell_ma_o(cell_ma), .cell_valid_o(cell_valid));

  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step

  // Measures from one rising edge of leg A: its high time, its period and the delay to leg B rising.
  task automatic legs(output int h, output int p, output int d);
    logic pa, pb;
    int   k;
    h = 0; p = 0; d = -1; k = 0; pa = 1'b0; pb = 1'b1;
    while (leg_a !== 1'b0 && k < 200) begin step(1); k++; end
    while (leg_a !== 1'b1 && k < 400) begin step(1); k++; end
    for (int i = 0; i < 160; i++) begin
      if (i > 0 && p == 0 && leg_a === 1'b1 && pa === 1'b0) p = i;
      if (p == 0 && leg_a === 1'b1) h++;
      if (d < 0 && leg_b === 1'b1 && pb === 1'b0) d = i;
      pa = leg_a;
      pb = leg_b;
      step(1);
    end
  endtask : legs

  initial begin
    #4000000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    ref_clk = 0; arst_n = 0; addr = 0; wdata = 0; wr = 0; rd = 0; req = 0; slow = 0; ma = 0; busy = 0;
    error_cnt = 0; compares = 0;
    void'($urandom(32'hdef2));
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    step(1);
    check({leg_a, leg_b, damp, trans, coil_sel}, 32'h0);
    rd_reg(8'h10, v); check(v, 32'd18000);
    rd_reg(8'h0c, v); check(v & 32'h7f, 32'h01);
    rd_reg(8'h20, v); check(v, 32'h0);
    wr_reg(8'h04, 32'h3);
    wr_reg(8'h00, 32'h3);
    step(2);
    check({damp, trans}, 32'h2);
    check(coil_sel, 32'h08);
    rd_reg(8'h0c, v); check(v & 32'h7f, 32'h22);
    rd_reg(8'h00, v); check(v, 32'h1);
    legs(hi, per, dly);
    check(hi, 32'd38);
    check(per, 32'd76);
    check(dly, 32'd38);
    wr_reg(8'h00, 32'h5);
    t1 = cyc;
    step(2);
    check({damp, trans}, 32'h3);
    while (damp !== 1'b0 && cyc - t1 < 1100) step(1);
    check(int'(cyc - t1 >= 1000 && cyc - t1 <= 1001), 32'h1);
    check(trans, 32'h1);
    t1 = cyc;
    rd_reg(8'h0c, v); check(v & 32'h7f, 32'h48);
    while (trans !== 1'b0 && cyc - t1 < 1100) step(1);
    check(cyc - t1, 32'd1000);
    check({damp, trans}, 32'h0);
    rd_reg(8'h0c, v); check(v & 32'h7f, 32'h10);
    ph = 18000;
    for (int i = 0; i < 12; i++) begin
      two = (i == 0) ? 0 : $urandom_range(0, 1);
      tgt = (i == 0) ? 1000 : $urandom_range(0, 6000);
      m = (i == 0) ? 1001 : $urandom_range(0, 7000);
      wr_reg(8'h00, two ? 32'h9 : 32'h1);
      wr_reg(8'h08, tgt);
      @(posedge ref_clk);
      req <= 1'b1;
      ma <= m[15:0];
      slow <= i[0];
      @(posedge ref_clk);
      req <= 1'b0;
      e = 0;
      while (cell_valid !== 1'b1 && e < 12) begin step(1); e++; end
      step(3);
      lim = two ? 5000 : 3000;
      u = tgt - m;
      if (u > 2000) u = 2000;
      if (u < -2000) u = -2000;
      if (m > lim) u = (lim - m < -2000) ? -2000 : lim - m;
      ph = ph + u;
      if (ph > 18000) ph = 18000;
      if (ph < 0) ph = 0;
      rd_reg(8'h10, v); check(v, ph);
      rd_reg(8'h14, v); check(v, m);
      rd_reg(8'h0c, v); check(v[7], m > lim);
      check(coil_sel, two ? 32'h18 : 32'h08);
    end
    legs(hi, per, dly);
    e = ph * 76 / 36000;
    check(per, 32'd76);
    if (e > 2 && e < 73) check(int'(dly >= e - 1 && dly <= e + 1), 32'h1);
    wr_reg(8'h04, 32'h7);
    wr_reg(8'h00, 32'hb);
    step(3);
    check({damp, trans}, 32'h2);
    rd_reg(8'h10, v); check(v, 32'd18000);
    check(coil_sel, 32'hc0);
    rd_reg(8'h00, v); check(v, 32'h9);
    @(posedge ref_clk);
    busy <= 8'h40;
    step(3);
    check(coil_sel, 32'h0);
    rd_reg(8'h0c, v); check(v[8], 32'h1);
    @(posedge ref_clk);
    busy <= 8'h00;
    step(3);
    check(coil_sel, 32'hc0);
    wr_reg(8'h00, 32'h0);
    step(2);
    check({leg_a, leg_b, damp, trans, coil_sel}, 32'h0);
    rd_reg(8'h0c, v); check(v & 32'h7f, 32'h01);
    tally_and_finish();
  end
endmodule : pscp_ctrl_tb

//--- dv/pscp_sense_model.sv
// Far-side model: the cell current sense path that hands the controller one RMS sample per request.
// Assumes the bench requests samples only while power is being transferred; answers promptly or slowly.
module pscp_sense_model (
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        req_i,
  input  wire logic        slow_i,
  input  wire logic [15:0] ma_i,
  output logic      [15:0] cell_ma_o,
  output logic             cell_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        pend;
  logic [2:0]  wait_cnt;
  logic [15:0] hold;
  // Between samples the current bus toggles, so a stale value never looks like fresh data.
  always @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cell_ma_o    <= 16'h0000;
      cell_valid_o <= 1'b0;
      pend         <= 1'b0;
      wait_cnt     <= 3'h0;
      hold         <= 16'h0000;
    end else begin
      cell_valid_o <= 1'b0;
      if (req_i) begin
        pend     <= 1'b1;
        hold     <= ma_i;
        wait_cnt <= slow_i ? 3'h5 : 3'h0;
        cell_ma_o <= ~cell_ma_o;
      end else if (pend && wait_cnt == 3'h0) begin
        cell_ma_o    <= hold;
        cell_valid_o <= 1'b1;
        pend         <= 1'b0;
      end else begin
        if (pend) wait_cnt <= wait_cnt - 3'h1;
        cell_ma_o <= ~cell_ma_o;
      end
    end
  end
endmodule : pscp_sense_model

//--- rtl/pscp_ctrl.sv
// Power controller of a coil-array inductive transmitter: bridge legs, impedance switches, coil mux.
// Assumes a 10 MHz clock, synchronous inputs and a sensed RMS cell current in 1 mA steps.
`include "pscp_map.svh"
module pscp_ctrl #(
  parameter int NCOIL = 8
) (
  input  wire logic             ref_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic [7:0]       addr_i,
  input  wire logic [31:0]      wdata_i,
  input  wire logic             wr_i,
  input  wire logic             rd_i,
  output logic      [31:0]      rdata_o,
  input  wire logic [15:0]      cell_ma_i,
  input  wire logic             cell_valid_i,
  input  wire logic [NCOIL-1:0] coil_busy_i,
  output logic [NCOIL-1:0]      coil_sel_o,
  output logic                  leg_a_o,
  output logic                  leg_b_o,
  output logic                  ping_damping_switch_o,
  output logic                  transition_switch_o
);
  localparam int IW = $clog2(NCOIL);
  localparam logic [7:0] PER = 8'(`PSCP_PER_CYC);
  localparam logic [7:0] HALF = 8'(`PSCP_PER_CYC / 2);
  localparam logic [14:0] PH_MAX = 15'(`PSCP_PHASE_MAX_CD);
  localparam logic [16:0] FULL = 17'(`PSCP_FULL_CD);
  localparam logic [10:0] TCYC = 11'(`PSCP_TRANS_CYC);
  localparam logic signed [17:0] CAP = 18'(`PSCP_LOOP_CAP);

  function automatic logic signed [17:0] clamp_cap(input logic signed [17:0] v);
    if (v > CAP) return CAP;
    if (v < -CAP) return -CAP;
    return v;
  endfunction : clamp_cap

  function automatic pscp_pkg::pscp_mode_e sw_mode(input pscp_pkg::pscp_sw_s s);
    if (s.trans) return pscp_pkg::PSCP_MODE_NORMAL;
    if (s.damp) return pscp_pkg::PSCP_MODE_DAMPED;
    return pscp_pkg::PSCP_MODE_RESONANT;
  endfunction : sw_mode

  // Control group: registers, sequencer, loop, mux and switches.
  pscp_pkg::pscp_state_e state_reg, state_next;
  pscp_pkg::pscp_cfg_s   cfg_reg, cfg_next;
  pscp_pkg::pscp_sw_s    sw_reg, sw_next;
  logic [IW-1:0]         coil_reg, coil_next;
  logic [15:0]           target_reg, target_next;
  logic [15:0]           meas_reg, meas_next;
  logic [14:0]           phase_reg, phase_next;
  logic [10:0]           tmr_reg, tmr_next;
  logic                  limit_reg, limit_next;
  logic                  confl_reg, confl_next;
  logic [NCOIL-1:0]      sel_reg, sel_next;
  logic [31:0]           rdata_reg, rdata_next;

  always_comb begin
    logic                  ping_cmd;
    logic                  pwr_cmd;
    logic [IW-1:0]         idx;
    logic [NCOIL-1:0]      req;
    logic [15:0]           lim;
    logic signed [17:0]    err;
    logic signed [17:0]    u;
    logic signed [17:0]    sum;
    ping_cmd = 1'b0;
    pwr_cmd = 1'b0;
    idx = '0;
    req = '0;
    lim = '0;
    err = '0;
    u = '0;
    sum = '0;
    state_next = state_reg;
    cfg_next = cfg_reg;
    coil_next = coil_reg;
    target_next = target_reg;
    meas_next = meas_reg;
    phase_next = phase_reg;
    tmr_next = tmr_reg;
    limit_next = limit_reg;
    if (wr_i && addr_i == `PSCP_OFS_CTRL) begin
      cfg_next.enable = wdata_i[`PSCP_CTRL_EN_BIT];
      cfg_next.two_coil = wdata_i[`PSCP_CTRL_TWO_BIT];
      ping_cmd = wdata_i[`PSCP_CTRL_PING_BIT];
      pwr_cmd = wdata_i[`PSCP_CTRL_POWER_BIT];
    end
    if (wr_i && addr_i == `PSCP_OFS_COIL) coil_next = wdata_i[IW-1:0];
    if (wr_i && addr_i == `PSCP_OFS_TARGET) target_next = wdata_i[15:0];
    // Sensed current keeps its 1 mA step; no bits are dropped.
    if (cell_valid_i) meas_next = cell_ma_i;
    lim = cfg_reg.two_coil ? 16'(`PSCP_ILIM_TWO_MA) : 16'(`PSCP_ILIM_ONE_MA);
    unique case (state_reg)
      pscp_pkg::PSCP_IDLE: begin
        if (cfg_next.enable && ping_cmd) begin
          state_next = pscp_pkg::PSCP_PING;
          phase_next = PH_MAX;
        end
      end
      pscp_pkg::PSCP_PING: begin
        if (pwr_cmd) begin
          state_next = pscp_pkg::PSCP_TRANS1;
          tmr_next = '0;
        end
      end
      pscp_pkg::PSCP_TRANS1, pscp_pkg::PSCP_TRANS2: begin
        // Transition switch holds the matching inductor current through the damping release.
        tmr_next = tmr_reg + 11'h001;
        if (tmr_reg == TCYC - 11'h001) begin
          tmr_next = '0;
          state_next = (state_reg == pscp_pkg::PSCP_TRANS1) ? pscp_pkg::PSCP_TRANS2 : pscp_pkg::PSCP_POWER;
        end
      end
      pscp_pkg::PSCP_POWER: begin
        if (ping_cmd) begin
          state_next = pscp_pkg::PSCP_PING;
          phase_next = PH_MAX;
        end else if (cell_valid_i) begin
          err = $signed({2'b00, target_reg}) - $signed({2'b00, cell_ma_i});
          u = clamp_cap(18'(`PSCP_KP * err));
          limit_next = cell_ma_i > lim;
          // The cap overrides the loop whenever the cell current is too high.
          if (cell_ma_i > lim) u = clamp_cap($signed({2'b00, lim}) - $signed({2'b00, cell_ma_i}));
          sum = $signed({3'b000, phase_reg}) + 18'(u * `PSCP_SCALE_CD);
          if (sum < 0) phase_next = '0;
          else if (sum > $signed({3'b000, PH_MAX})) phase_next = PH_MAX;
          else phase_next = sum[14:0];
        end
      end
    endcase
    if (!cfg_next.enable) begin
      state_next = pscp_pkg::PSCP_IDLE;
      limit_next = 1'b0;
    end
    unique case (state_next)
      pscp_pkg::PSCP_IDLE:   sw_next = '{damp: 1'b0, trans: 1'b0};
      pscp_pkg::PSCP_PING:   sw_next = '{damp: 1'b1, trans: 1'b0};
      pscp_pkg::PSCP_TRANS1: sw_next = '{damp: 1'b1, trans: 1'b1};
      pscp_pkg::PSCP_TRANS2: sw_next = '{damp: 1'b0, trans: 1'b1};
      pscp_pkg::PSCP_POWER:  sw_next = '{damp: 1'b0, trans: 1'b0};
    endcase
    // Two coils are a neighbouring pair, which always overlap.
    idx = coil_next;
    if (cfg_next.two_coil && idx > IW'(NCOIL - 2)) idx = IW'(NCOIL - 2);
    req = cfg_next.two_coil ? (NCOIL'(3) << idx) : (NCOIL'(1) << idx);
    // Coils held by another inverter are never joined to this one.
    confl_next = (req & coil_busy_i) != '0;
    sel_next = (state_next != pscp_pkg::PSCP_IDLE && !confl_next) ? req : '0;
    rdata_next = '0;
    if (rd_i) begin
      unique case (addr_i)
        `PSCP_OFS_CTRL:    rdata_next = 32'({cfg_reg.two_coil, 2'b00, cfg_reg.enable});
        `PSCP_OFS_COIL:    rdata_next = 32'(coil_reg);
        `PSCP_OFS_TARGET:  rdata_next = 32'(target_reg);
        `PSCP_OFS_STATUS:  rdata_next = 32'({confl_reg, limit_reg, sw_mode(sw_reg), state_reg});
        `PSCP_OFS_PHASE:   rdata_next = 32'(phase_reg);
        `PSCP_OFS_CURRENT: rdata_next = 32'(meas_reg);
        default:           rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg  <= pscp_pkg::PSCP_IDLE;
      cfg_reg    <= '0;
      sw_reg     <= '0;
      coil_reg   <= IW'(`PSCP_RST_COIL);
      target_reg <= `PSCP_RST_TARGET;
      meas_reg   <= '0;
      phase_reg  <= 15'(`PSCP_PHASE_MAX_CD);
      tmr_reg    <= '0;
      limit_reg  <= 1'b0;
      confl_reg  <= 1'b0;
      sel_reg    <= '0;
      rdata_reg  <= '0;
    end else begin
      state_reg  <= state_next;
      cfg_reg    <= cfg_next;
      sw_reg     <= sw_next;
      coil_reg   <= coil_next;
      target_reg <= target_next;
      meas_reg   <= meas_next;
      phase_reg  <= phase_next;
      tmr_reg    <= tmr_next;
      limit_reg  <= limit_next;
      confl_reg  <= confl_next;
      sel_reg    <= sel_next;
      rdata_reg  <= rdata_next;
    end
  end

  // Inverter group: period counter, dithered leg delay and leg outputs.
  // The delay resolves 0.01 degree on average by carrying the remainder over periods.
  logic [7:0]  cnt_reg, cnt_next;
  logic [7:0]  dly_reg, dly_next;
  logic [15:0] acc_reg, acc_next;
  logic        leg_a_reg, leg_a_next;
  logic        leg_b_reg, leg_b_next;

  always_comb begin
    logic [21:0] prod;
    logic [16:0] asum;
    logic [7:0]  t;
    logic        run;
    prod = 22'(phase_reg) * 22'(PER);
    asum = 17'(acc_reg) + 17'(prod % 22'(FULL));
    t = '0;
    run = state_reg != pscp_pkg::PSCP_IDLE;
    cnt_next = (cnt_reg == PER - 8'h01) ? 8'h00 : cnt_reg + 8'h01;
    dly_next = dly_reg;
    acc_next = acc_reg;
    if (cnt_reg == PER - 8'h01) begin
      dly_next = 8'(prod / 22'(FULL));
      acc_next = asum[15:0];
      if (asum >= FULL) begin
        dly_next = 8'(prod / 22'(FULL)) + 8'h01;
        acc_next = 16'(asum - FULL);
      end
    end
    t = (cnt_reg >= dly_reg) ? cnt_reg - dly_reg : 8'(cnt_reg + PER - dly_reg);
    leg_a_next = run && cnt_reg < HALF;
    leg_b_next = run && t < HALF;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_reg   <= '0;
      dly_reg   <= '0;
      acc_reg   <= '0;
      leg_a_reg <= 1'b0;
      leg_b_reg <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      dly_reg   <= dly_next;
      acc_reg   <= acc_next;
      leg_a_reg <= leg_a_next;
      leg_b_reg <= leg_b_next;
    end
  end

  assign rdata_o = rdata_reg;
  assign coil_sel_o = sel_reg;
  assign leg_a_o = leg_a_reg;
  assign leg_b_o = leg_b_reg;
  assign ping_damping_switch_o = sw_reg.damp;
  assign transition_switch_o = sw_reg.trans;

  // Helper: length of the current high run of the first leg, cleared to zero while it is low.
  logic [7:0] hi_run;
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) hi_run <= '0;
    else hi_run <= leg_a_o ? hi_run + 8'h01 : 8'h00;
  end

  property p_ping_entry;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    $rose(state_reg == pscp_pkg::PSCP_PING) |-> phase_reg == PH_MAX && ping_damping_switch_o && !transition_switch_o;
  endproperty
  a_ping_entry: assert property (p_ping_entry) else $error("ping entry setup wrong");
  property p_sw_state;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    (state_reg == pscp_pkg::PSCP_POWER |-> !ping_damping_switch_o && !transition_switch_o) and
    (state_reg == pscp_pkg::PSCP_PING |-> ping_damping_switch_o && !transition_switch_o);
  endproperty
  a_sw_state: assert property (p_sw_state) else $error("switch pattern wrong");
  property p_mode;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    rd_i && addr_i == `PSCP_OFS_STATUS |=> (rdata_o[6:5] == 2'h2) == $past(transition_switch_o);
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode wrong");
  property p_smooth;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    $rose(state_reg == pscp_pkg::PSCP_POWER) |-> $past(transition_switch_o) && !$past(ping_damping_switch_o);
  endproperty
  a_smooth: assert property (p_smooth) else $error("resonant entry without transition");

  property p_raise;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    state_reg == pscp_pkg::PSCP_POWER && cell_valid_i && !wr_i && cell_ma_i < target_reg &&
    cell_ma_i <= 16'(`PSCP_ILIM_ONE_MA) |=> phase_reg >= $past(phase_reg);
  endproperty
  a_raise: assert property (p_raise) else $error("phase fell while current low");

  property p_cap;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    state_reg == pscp_pkg::PSCP_POWER && cell_valid_i && !wr_i && cell_ma_i > 16'(`PSCP_ILIM_TWO_MA)
    |=> phase_reg < $past(phase_reg) || phase_reg == '0;
  endproperty
  a_cap: assert property (p_cap) else $error("current cap ignored");

  property p_step;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    state_reg == pscp_pkg::PSCP_POWER && $past(state_reg) == pscp_pkg::PSCP_POWER |->
    (phase_reg >= $past(phase_reg) ? phase_reg - $past(phase_reg) : $past(phase_reg) - phase_reg) <= 15'(`PSCP_LOOP_CAP);
  endproperty
  a_step: assert property (p_step) else $error("loop step over cap");

  property p_coils;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    $countones(coil_sel_o) <= 2 && ($countones(coil_sel_o) != 2 || (coil_sel_o & (coil_sel_o >> 1)) != '0);
  endproperty
  a_coils: assert property (p_coils) else $error("illegal coil set");

  property p_excl;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    ##1 (coil_sel_o & $past(coil_busy_i)) == '0;
  endproperty
  a_excl: assert property (p_excl) else $error("coil shared with another inverter");

  // A high run that ends within 40 cycles of leaving idle may be cut short, so it is not judged.
  property p_duty;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
    $fell(leg_a_o) && $past(state_reg) != pscp_pkg::PSCP_IDLE && $past(state_reg, 2) != pscp_pkg::PSCP_IDLE
    && hi_run != 8'h00 && $past(state_reg, 40) != pscp_pkg::PSCP_IDLE |-> hi_run == HALF;
  endproperty
  a_duty: assert property (p_duty) else $error("leg duty wrong");

  c_ping:  cover property (@(posedge ref_clk_i) disable iff (!arst_n_i) $rose(state_reg == pscp_pkg::PSCP_PING));
  c_power: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i) $rose(state_reg == pscp_pkg::PSCP_POWER));
  c_limit: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i) $rose(limit_reg));
  c_confl: cover property (@(posedge ref_clk_i) disable iff (!arst_n_i) $rose(confl_reg));
endmodule : pscp_ctrl

//--- rtl/pscp_map.svh
// Constants of the phase-shift coil-array power controller: offsets, fields, resets and timing.
// Assumes inclusion by bare name; holds definitions only.
`ifndef PSCP_MAP_SVH
`define PSCP_MAP_SVH
`define PSCP_CLK_KHZ        10000
`define PSCP_FSW_KHZ        130
`define PSCP_PER_CYC        ((`PSCP_CLK_KHZ / `PSCP_FSW_KHZ) / 2 * 2)
`define PSCP_PHASE_MAX_CD   18000
`define PSCP_FULL_CD        36000
`define PSCP_KP             1
`define PSCP_KI             0
`define PSCP_KD             0
`define PSCP_LOOP_CAP       2000
`define PSCP_SCALE_CD       1
`define PSCP_ILIM_TWO_MA    5000
`define PSCP_ILIM_ONE_MA    3000
`define PSCP_TRANS_NS       100000
`define PSCP_TRANS_CYC      ((`PSCP_TRANS_NS * `PSCP_CLK_KHZ + 999999) / 1000000)
`define PSCP_OFS_CTRL       8'h00
`define PSCP_OFS_COIL       8'h04
`define PSCP_OFS_TARGET     8'h08
`define PSCP_OFS_STATUS     8'h0c
`define PSCP_OFS_PHASE      8'h10
`define PSCP_OFS_CURRENT    8'h14
`define PSCP_CTRL_EN_BIT    0
`define PSCP_CTRL_PING_BIT  1
`define PSCP_CTRL_POWER_BIT 2
`define PSCP_CTRL_TWO_BIT   3
`define PSCP_ST_MODE_POS    5
`define PSCP_ST_LIMIT_BIT   7
`define PSCP_ST_CONFL_BIT   8
`define PSCP_RST_TARGET     16'h0000
`define PSCP_RST_COIL       8'h00
`endif

//--- rtl/pscp_pkg.sv
// Types of the phase-shift coil-array power controller.
// Assumes the constants header is compiled alongside.
package pscp_pkg;
  typedef enum logic [4:0] {
    PSCP_IDLE   = 5'b00001,
    PSCP_PING   = 5'b00010,
    PSCP_TRANS1 = 5'b00100,
    PSCP_TRANS2 = 5'b01000,
    PSCP_POWER  = 5'b10000
  } pscp_state_e;

  typedef enum logic [1:0] {
    PSCP_MODE_RESONANT = 2'h0,
    PSCP_MODE_DAMPED   = 2'h1,
    PSCP_MODE_NORMAL   = 2'h2
  } pscp_mode_e;

  typedef struct packed {
    logic damp;
    logic trans;
  } pscp_sw_s;

  typedef struct packed {
    logic enable;
    logic two_coil;
  } pscp_cfg_s;
endpackage : pscp_pkg
